// *** hw/ep_params.svh ***
// constants of the endpoint state tracker: register offsets, field positions,
// command and event encodings, completion codes and reset values
// assumes an 8-bit register address and 32-bit register data
`ifndef EP_PARAMS_SVH
`define EP_PARAMS_SVH

// -------------------------------------------------------------
// register offsets
// -------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_DOORBELL 8'h04
`define OFS_STATUS 8'h08
`define OFS_EP_SEL 8'h0c
`define OFS_ENDPOINT_STATE_FIELD 8'h10

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_OP_MSB 3
`define CMD_EP_LSB 8
`define CMD_EP_MSB 12
`define CMD_ADD_BIT 16
`define CMD_DROP_BIT 17
`define CMD_DC_BIT 18
`define DOORBELL_TARGET_FIELD_LSB 0
`define DOORBELL_TARGET_FIELD_MSB 4
`define STAT_PEND_BIT 0
`define STAT_CODE_LSB 8
`define STAT_CODE_MSB 15
`define EPS_STATE_LSB 0
`define EPS_STATE_MSB 2
`define EPS_BUSY_BIT 3
`define EPS_SKIP_BIT 4

// -------------------------------------------------------------
// command opcodes
// -------------------------------------------------------------
`define OP_ADDR_DEV 4'h1
`define OP_CONFIG_EP 4'h2
`define OP_RESET_DEV 4'h3
`define OP_DISABLE_SLOT 4'h4
`define OP_RESET_EP 4'h5
`define OP_STOP_EP 4'h6
`define OP_SET_DEQ 4'h7

// -------------------------------------------------------------
// pipe event kinds
// -------------------------------------------------------------
`define KIND_STALL 4'h0
`define KIND_STREAM_TYPE 4'h1
`define KIND_STREAM_ID 4'h2
`define KIND_BABBLE 4'h3
`define KIND_EVENT_LOST 4'h4
`define KIND_TXN_ERR 4'h5
`define KIND_SPLIT_ERR 4'h6
`define KIND_TIMEOUT 4'h7
`define KIND_TRB_ERR 4'h8

// -------------------------------------------------------------
// completion codes and reset values
// -------------------------------------------------------------
`define CC_SUCCESS 8'h01
`define CC_CTX_STATE_ERR 8'h02
`define CC_BAD_OPCODE 8'h03
`define EP_SEL_RST 5'h00
`define CODE_RST 8'h00

`endif

// *** hw/ep_types_pkg.sv ***
// types shared by the endpoint state tracker and its per-endpoint cell
// assumes at most 32 endpoints per slot (5-bit endpoint index)
package ep_types_pkg;

  typedef enum logic [2:0] {
    EP_DISABLED,
    EP_RUNNING,
    EP_HALTED,
    EP_STOPPED,
    EP_ERROR
  } endpoint_state_field_t;

  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_SETTLE,
    CMD_FLUSH
  } cmd_seq_t;

  // per-endpoint decoded strobes, one cycle long, plus the add and drop flags taken straight from wdata
  typedef struct packed {
    logic addr_dev;
    logic cfg;
    logic add;
    logic drop;
    logic deconf;
    logic reset_dev;
    logic dis_slot;
    logic reset_ep;
    logic stop_ep;
    logic set_deq;
    logic doorbell;
    logic halt;
    logic trb_err;
    logic iso_tmo;
    logic ring_empty;
    logic tick;
  } ep_cmd_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [2:0] state;
  } ctx_wr_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [7:0] code;
  } cmpl_t;

endpackage

// *** hw/endpoint_state_field_cell.sv ***
// state of one endpoint: encoded state, busy/idle sub-state, isoch skip flag
// assumes the strobes of cmd come from logic on ref_clk, one cycle each
`timescale 1ns/1ps

module endpoint_state_field_cell #(
  parameter bit IS_DEFAULT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input ep_types_pkg::ep_cmd_t cmd,
  output ep_types_pkg::endpoint_state_field_t state_r,
  output logic busy_r,
  output logic skip_r,
  output logic changed_r
);
  import ep_types_pkg::*;

  endpoint_state_field_t state_nxt;

  // -------------------------------------------------------------
  // transitions
  // -------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (cmd.dis_slot) begin
      state_nxt = EP_DISABLED;
    end else if (!IS_DEFAULT && (cmd.reset_dev || cmd.deconf || (cmd.cfg && !cmd.add && cmd.drop))) begin
      state_nxt = EP_DISABLED;
    end else begin
      case (state_r)
        EP_DISABLED: begin
          if (IS_DEFAULT ? cmd.addr_dev : (cmd.cfg && cmd.add && !cmd.drop)) begin
            state_nxt = EP_RUNNING;
          end
        end
        EP_RUNNING: begin
          if (cmd.halt) begin
            state_nxt = EP_HALTED;
          end else if (cmd.trb_err) begin
            state_nxt = EP_ERROR;
          end else if (cmd.stop_ep) begin
            state_nxt = EP_STOPPED;
          end
        end
        EP_HALTED: begin
          if (cmd.reset_ep) begin
            state_nxt = EP_STOPPED;
          end
        end
        EP_ERROR: begin
          if (cmd.set_deq) begin
            state_nxt = EP_STOPPED;
          end
        end
        EP_STOPPED: begin
          // configure never restarts the default control endpoint
          if (cmd.doorbell || (!IS_DEFAULT && cmd.cfg && cmd.add && cmd.drop)) begin
            state_nxt = EP_RUNNING;
          end
        end
        default: begin
          state_nxt = EP_DISABLED;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= EP_DISABLED;
      changed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      changed_r <= (state_nxt != state_r);
    end
  end

  // -------------------------------------------------------------
  // busy and idle sub-states of running
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      busy_r <= 1'b0;
    end else if (state_nxt != EP_RUNNING) begin
      busy_r <= 1'b0;
    end else if (cmd.doorbell) begin
      busy_r <= 1'b1;
    end else if (cmd.ring_empty) begin
      busy_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // isoch timeout: no more transactions until the next interval
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      skip_r <= 1'b0;
    end else begin
      skip_r <= (state_r == EP_RUNNING && cmd.iso_tmo) || (skip_r && !cmd.tick);
    end
  end

endmodule

// *** hw/endpoint_state_field_tracker.sv ***
// endpoint state tracker of one device slot: commands and doorbells from
// software, errors from the pipe, context write-back and completions
// assumes pipe_evt_* come from another clock domain and are held stable
// around a rising edge of pipe_evt_valid; all other inputs are on ref_clk
//
// Overview of operation
// - address device moves default control endpoint disabled to running
// - configure with add 1 drop 0 enables a non-default endpoint
// - configure add 0 drop 1, or reset device, disables non-default endpoint
// - deconfigure disables every endpoint except the default control one
// - disable slot disables all endpoints, default control included
// - configure with add 1 drop 1 restarts a stopped non-default endpoint
// - configure never changes the default control endpoint state
// - halt-class pipe errors move a running endpoint to halted
// - reset endpoint moves halted to stopped
// - stop on halted or error keeps state, completes with context error
// - stall on any control stage halts the default control endpoint
// - doorbell moves a stopped endpoint back to running
// - trb error moves a running endpoint to error
// - set dequeue pointer moves error to stopped
// - stop endpoint moves running to stopped, ring handed to software
// - empty ring makes running endpoint idle, still running
// - stopped endpoint never emits transfer events
// - context shows running before first transfer event after doorbell
// - non-isoch timeout halts endpoint, no retry
// - isoch timeout skips rest of interval, no halt
// - context written no later than the command completion
// - doorbells to halted or error endpoints are ignored
`timescale 1ns/1ps
`include "ep_params.svh"

module endpoint_state_field_tracker #(
  parameter int NUM_EP = 31
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata_r,
  input wire logic pipe_evt_valid,
  input wire logic pipe_evt_iso,
  input wire logic [3:0] pipe_evt_kind,
  input wire logic [4:0] pipe_evt_ep,
  input wire logic ring_empty_valid,
  input wire logic [4:0] ring_empty_ep,
  input wire logic interval_tick,
  input wire logic xfer_evt_req,
  input wire logic [4:0] xfer_evt_ep,
  output logic xfer_evt_ok_r,
  output logic [NUM_EP-1:0] issue_ok_r,
  output ep_types_pkg::ctx_wr_t ctx_wr_r,
  output ep_types_pkg::cmpl_t cmpl_r
);
  import ep_types_pkg::*;

  localparam int FLUSH_MAX = 40;

  function automatic logic blocked(input endpoint_state_field_t s);
    blocked = (s == EP_HALTED) || (s == EP_ERROR);
  endfunction

  function automatic logic [4:0] first_set(input logic [NUM_EP-1:0] v);
    first_set = 5'h00;
    for (int k = NUM_EP - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 5'(k);
      end
    end
  endfunction

  endpoint_state_field_t st [NUM_EP];
  ep_cmd_t ec [NUM_EP];
  logic [NUM_EP-1:0] busy;
  logic [NUM_EP-1:0] skip;
  logic [NUM_EP-1:0] chg;
  logic [NUM_EP-1:0] dirty_r;
  logic [NUM_EP-1:0] clr;
  logic [4:0] wr_idx;
  cmd_seq_t seq_r;
  logic [7:0] code_r;
  logic [4:0] cmd_ep_r;
  logic [4:0] ep_sel_r;

  // -------------------------------------------------------------
  // register port decode
  // -------------------------------------------------------------
  logic cmd_go;
  logic db_go;
  logic [3:0] op;
  logic [4:0] cep;
  logic [4:0] db_ep;
  logic add_f;
  logic drop_f;
  logic deconfigure_flag;

  // a command arriving while one is in flight is dropped
  assign cmd_go = wr_stb && (addr == `OFS_CMD) && (seq_r == CMD_IDLE);
  assign db_go = wr_stb && (addr == `OFS_DOORBELL);
  assign op = wdata[`CMD_OP_MSB:`CMD_OP_LSB];
  assign cep = wdata[`CMD_EP_MSB:`CMD_EP_LSB];
  assign add_f = wdata[`CMD_ADD_BIT];
  assign drop_f = wdata[`CMD_DROP_BIT];
  assign deconfigure_flag = wdata[`CMD_DC_BIT];
  assign db_ep = wdata[`DOORBELL_TARGET_FIELD_MSB:`DOORBELL_TARGET_FIELD_LSB];

  // -------------------------------------------------------------
  // pipe event synchroniser
  // -------------------------------------------------------------
  logic [10:0] p1_r;
  logic [10:0] p2_r;
  logic p3_r;
  logic pevt;
  logic [3:0] pk;
  logic [4:0] pep;
  logic piso;
  logic halt_k;
  logic trb_k;
  logic iso_k;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      p1_r <= 11'h000;
      p2_r <= 11'h000;
      p3_r <= 1'b0;
    end else begin
      p1_r <= {pipe_evt_valid, pipe_evt_iso, pipe_evt_kind, pipe_evt_ep};
      p2_r <= p1_r;
      p3_r <= p2_r[10];
    end
  end

  assign pevt = p2_r[10] && !p3_r;
  assign piso = p2_r[9];
  assign pk = p2_r[8:5];
  assign pep = p2_r[4:0];
  // stall, stream, babble, lost event, transaction and split errors halt
  assign halt_k = pevt && ((pk <= `KIND_SPLIT_ERR) || (pk == `KIND_TIMEOUT && !piso));
  assign trb_k = pevt && (pk == `KIND_TRB_ERR);
  assign iso_k = pevt && (pk == `KIND_TIMEOUT) && piso;

  // -------------------------------------------------------------
  // per-endpoint strobes and cells
  // -------------------------------------------------------------
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    always_comb begin
      ec[i] = '0;
      ec[i].addr_dev = cmd_go && (op == `OP_ADDR_DEV) && (i == 0);
      ec[i].cfg = cmd_go && (op == `OP_CONFIG_EP) && !deconfigure_flag && (cep == 5'(i));
      ec[i].add = add_f;
      ec[i].drop = drop_f;
      ec[i].deconf = cmd_go && (op == `OP_CONFIG_EP) && deconfigure_flag;
      ec[i].reset_dev = cmd_go && (op == `OP_RESET_DEV);
      ec[i].dis_slot = cmd_go && (op == `OP_DISABLE_SLOT);
      ec[i].reset_ep = cmd_go && (op == `OP_RESET_EP) && (cep == 5'(i));
      ec[i].stop_ep = cmd_go && (op == `OP_STOP_EP) && (cep == 5'(i));
      ec[i].set_deq = cmd_go && (op == `OP_SET_DEQ) && (cep == 5'(i));
      ec[i].doorbell = db_go && (db_ep == 5'(i));
      ec[i].halt = halt_k && (pep == 5'(i));
      ec[i].trb_err = trb_k && (pep == 5'(i));
      ec[i].iso_tmo = iso_k && (pep == 5'(i));
      ec[i].ring_empty = ring_empty_valid && (ring_empty_ep == 5'(i));
      ec[i].tick = interval_tick;
    end

    endpoint_state_field_cell #(
      .IS_DEFAULT(i == 0)
    ) u_cell (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .cmd(ec[i]),
      .state_r(st[i]),
      .busy_r(busy[i]),
      .skip_r(skip[i]),
      .changed_r(chg[i])
    );

    // no retry after a timeout: a halted or skipping endpoint issues nothing
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        issue_ok_r[i] <= 1'b0;
      end else begin
        issue_ok_r[i] <= (st[i] == EP_RUNNING) && busy[i] && !skip[i];
      end
    end
  end

  // -------------------------------------------------------------
  // context write-back of changed states
  // -------------------------------------------------------------
  assign wr_idx = first_set(dirty_r);
  always_comb begin
    clr = '0;
    clr[wr_idx] = |dirty_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dirty_r <= '0;
    end else begin
      // a new change wins over the write-back clear
      dirty_r <= (dirty_r & ~clr) | chg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctx_wr_r <= '0;
    end else begin
      ctx_wr_r.valid <= |dirty_r;
      ctx_wr_r.idx <= wr_idx;
      ctx_wr_r.state <= 3'(st[wr_idx]);
    end
  end

  // -------------------------------------------------------------
  // command sequencing and completion
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      seq_r <= CMD_IDLE;
    end else begin
      case (seq_r)
        CMD_IDLE: begin
          if (cmd_go) begin
            seq_r <= CMD_SETTLE;
          end
        end
        CMD_SETTLE: begin
          seq_r <= CMD_FLUSH;
        end
        CMD_FLUSH: begin
          if (dirty_r == '0 && chg == '0) begin
            seq_r <= CMD_IDLE;
          end
        end
        default: begin
          seq_r <= CMD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      code_r <= `CODE_RST;
      cmd_ep_r <= 5'h00;
    end else if (cmd_go) begin
      cmd_ep_r <= cep;
      if (op == `OP_STOP_EP && cep < 5'(NUM_EP) && blocked(st[cep])) begin
        code_r <= `CC_CTX_STATE_ERR;
      end else if (op >= `OP_ADDR_DEV && op <= `OP_SET_DEQ) begin
        code_r <= `CC_SUCCESS;
      end else begin
        code_r <= `CC_BAD_OPCODE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cmpl_r <= '0;
    end else begin
      cmpl_r.valid <= (seq_r == CMD_FLUSH) && (dirty_r == '0) && (chg == '0);
      cmpl_r.idx <= cmd_ep_r;
      cmpl_r.code <= code_r;
    end
  end

  // -------------------------------------------------------------
  // transfer event gate
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      xfer_evt_ok_r <= 1'b0;
    end else begin
      xfer_evt_ok_r <= xfer_evt_req && (xfer_evt_ep < 5'(NUM_EP)) && (st[xfer_evt_ep] != EP_STOPPED) &&
        (st[xfer_evt_ep] != EP_DISABLED) && !dirty_r[xfer_evt_ep] && !chg[xfer_evt_ep];
    end
  end

  // -------------------------------------------------------------
  // register read-back
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ep_sel_r <= `EP_SEL_RST;
    end else if (wr_stb && addr == `OFS_EP_SEL) begin
      ep_sel_r <= wdata[4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (rd_stb) begin
        case (addr)
          `OFS_STATUS: begin
            rdata_r[`STAT_PEND_BIT] <= (seq_r != CMD_IDLE);
            rdata_r[`STAT_CODE_MSB:`STAT_CODE_LSB] <= code_r;
          end
          `OFS_EP_SEL: begin
            rdata_r[4:0] <= ep_sel_r;
          end
          `OFS_ENDPOINT_STATE_FIELD: begin
            if (ep_sel_r < 5'(NUM_EP)) begin
              rdata_r[`EPS_STATE_MSB:`EPS_STATE_LSB] <= 3'(st[ep_sel_r]);
              rdata_r[`EPS_BUSY_BIT] <= busy[ep_sel_r];
              rdata_r[`EPS_SKIP_BIT] <= skip[ep_sel_r];
            end
          end
          default: begin
            rdata_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic nondef_dis;
  always_comb begin
    nondef_dis = 1'b1;
    for (int k = 1; k < NUM_EP; k++) begin
      if (st[k] != EP_DISABLED) begin
        nondef_dis = 1'b0;
      end
    end
  end

  sequence s_cmd(logic [3:0] o);
    cmd_go && (op == o) && !pevt;
  endsequence

  sequence s_tgt(endpoint_state_field_t s);
    (cep != 5'h00) && (cep < 5'(NUM_EP)) && (st[cep] == s);
  endsequence

  a_addr_dev_run: assert property (s_cmd(`OP_ADDR_DEV) ##0 st[0] == EP_DISABLED |=> st[0] == EP_RUNNING)
    else $error("address device did not start default endpoint");
  a_cfg_add_run: assert property (s_cmd(`OP_CONFIG_EP) ##0 (!deconfigure_flag && add_f && !drop_f)
    ##0 s_tgt(EP_DISABLED) |=> st[$past(cep)] == EP_RUNNING)
    else $error("configure add did not enable endpoint");
  a_cfg_drop_dis: assert property (s_cmd(`OP_CONFIG_EP) ##0 (!deconfigure_flag && !add_f && drop_f)
    ##0 (cep != 5'h00 && cep < 5'(NUM_EP)) |=> st[$past(cep)] == EP_DISABLED)
    else $error("configure drop did not disable endpoint");
  a_reset_dev_dis: assert property (s_cmd(`OP_RESET_DEV) |=> nondef_dis)
    else $error("reset device left an endpoint enabled");
  a_deconfig_all: assert property (s_cmd(`OP_CONFIG_EP) ##0 deconfigure_flag
    |=> nondef_dis && st[0] == $past(st[0]))
    else $error("deconfigure wrong");
  a_slot_disable: assert property (s_cmd(`OP_DISABLE_SLOT) |=> nondef_dis && st[0] == EP_DISABLED)
    else $error("disable slot left an endpoint enabled");
  a_cfg_restart: assert property (s_cmd(`OP_CONFIG_EP) ##0 (!deconfigure_flag && add_f && drop_f)
    ##0 s_tgt(EP_STOPPED) |=> st[$past(cep)] == EP_RUNNING)
    else $error("configure did not restart stopped endpoint");
  a_cfg_dflt_kept: assert property (s_cmd(`OP_CONFIG_EP) ##0 cep == 5'h00 |=> st[0] == $past(st[0]))
    else $error("configure changed default endpoint");
  a_halt_on_err: assert property (halt_k && !cmd_go && pep < 5'(NUM_EP) && st[pep] == EP_RUNNING
    |=> st[$past(pep)] == EP_HALTED)
    else $error("pipe error did not halt endpoint");
  a_reset_ep_stop: assert property (s_cmd(`OP_RESET_EP) ##0 cep < 5'(NUM_EP) && st[cep] == EP_HALTED
    |=> st[$past(cep)] == EP_STOPPED)
    else $error("reset endpoint did not stop halted endpoint");
  a_stop_ctx_err: assert property (s_cmd(`OP_STOP_EP) ##0 cep < 5'(NUM_EP) && blocked(st[cep])
    |=> st[cmd_ep_r] == $past(st[cep]) ##[0:FLUSH_MAX] (cmpl_r.valid && cmpl_r.code == `CC_CTX_STATE_ERR))
    else $error("stop on halted or error endpoint mishandled");
  a_db_restart: assert property (db_go && !pevt && db_ep < 5'(NUM_EP) && st[db_ep] == EP_STOPPED
    |=> st[$past(db_ep)] == EP_RUNNING)
    else $error("doorbell did not restart endpoint");
  a_trb_err: assert property (trb_k && !cmd_go && pep < 5'(NUM_EP) && st[pep] == EP_RUNNING
    |=> st[$past(pep)] == EP_ERROR)
    else $error("trb error did not reach error state");
  a_set_deq_stop: assert property (s_cmd(`OP_SET_DEQ) ##0 cep < 5'(NUM_EP) && st[cep] == EP_ERROR
    |=> st[$past(cep)] == EP_STOPPED)
    else $error("set dequeue did not stop errored endpoint");
  a_stop_running: assert property (s_cmd(`OP_STOP_EP) ##0 cep < 5'(NUM_EP) && st[cep] == EP_RUNNING
    |=> st[$past(cep)] == EP_STOPPED)
    else $error("stop did not stop running endpoint");
  a_idle_in_run: assert property (ring_empty_valid && !db_go && !cmd_go && !pevt && ring_empty_ep < 5'(NUM_EP)
    && st[ring_empty_ep] == EP_RUNNING |=> st[$past(ring_empty_ep)] == EP_RUNNING && !busy[$past(ring_empty_ep)])
    else $error("empty ring left running or stayed busy");
  a_no_xfer_stop: assert property (xfer_evt_ok_r |-> $past(st[xfer_evt_ep]) != EP_STOPPED
    && !$past(dirty_r[xfer_evt_ep]))
    else $error("transfer event allowed while stopped or context stale");
  a_iso_skip: assert property (iso_k && !cmd_go && !interval_tick && pep < 5'(NUM_EP) && st[pep] == EP_RUNNING
    |=> st[$past(pep)] == EP_RUNNING && skip[$past(pep)] ##1 !issue_ok_r[$past(pep, 2)])
    else $error("isoch timeout handled wrongly");
  a_ctx_before_done: assert property (cmpl_r.valid |-> $past(dirty_r) == '0 && $past(chg) == '0)
    else $error("completion before context write-back");
  a_db_ignored: assert property (db_go && !pevt && db_ep < 5'(NUM_EP) && blocked(st[db_ep])
    |=> st[$past(db_ep)] == $past(st[db_ep]))
    else $error("doorbell changed halted or error endpoint");

endmodule

// *** dv/pipe_model.sv ***
// partner model of the usb pipe: turns a one-cycle go into one pipe event
// assumes go is driven on ref_clk; event lines are stable around the valid edge
`timescale 1ns/1ps
module pipe_model (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [3:0] k,
  input wire logic [4:0] e,
  output logic v,
  output logic [3:0] kind,
  output logic [4:0] ep
);
  initial begin
    v = 1'b0;
    kind = 4'hf;
    ep = 5'h1f;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        kind <= k;
        ep <= e;
        repeat (3) @(posedge ref_clk);
        v <= 1'b1;
        repeat (4) @(posedge ref_clk);
        v <= 1'b0;
        repeat (3) @(posedge ref_clk);
        // released lines show the inverse, never the stale value
        kind <= ~k;
        ep <= ~e;
      end
    end
  end
endmodule

// *** dv/endpoint_state_field_tracker_tb.sv ***
// testbench of the endpoint state tracker
// assumes pipe_model drives the pipe event valid, kind and endpoint inputs; the testbench drives pipe_evt_iso
`timescale 1ns/1ps
`include "ep_params.svh"
module endpoint_state_field_tracker_tb;
  import ep_types_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic go = 1'b0;
  logic req = 1'b0;
  logic re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata_r;
  logic [3:0] pk = 4'h0;
  logic [4:0] pe = 5'h00;
  logic [4:0] xe = 5'h00;
  logic [4:0] ree = 5'h00;
  logic iso = 1'b0;
  logic tick = 1'b0;
  logic v;
  logic ok;
  logic [3:0] kind;
  logic [4:0] pep;
  cmpl_t cmpl_r;
  ctx_wr_t cw;
  logic [30:0] iok;
  int fails = 0;
  int checked = 0;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  endpoint_state_field_tracker dut_u (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_r(rdata_r), .pipe_evt_valid(v), .pipe_evt_iso(iso), .pipe_evt_kind(kind),
    .pipe_evt_ep(pep), .ring_empty_valid(re), .ring_empty_ep(ree), .interval_tick(tick), .xfer_evt_req(req),
    .xfer_evt_ep(xe), .xfer_evt_ok_r(ok), .issue_ok_r(iok), .ctx_wr_r(cw), .cmpl_r(cmpl_r));
  pipe_model pipe_u (.ref_clk(ref_clk), .go(go), .k(pk), .e(pe), .v(v), .kind(kind), .ep(pep));
  // ---------------------------------------------
  // bus and check tasks
  // ---------------------------------------------
  task give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rdata_r;
  endtask
  task st(input logic [4:0] e, input logic [2:0] x);
    logic [31:0] d;
    wr(`OFS_EP_SEL, {27'h0, e});
    rd(`OFS_ENDPOINT_STATE_FIELD, d);
    chk(d[2:0], x);
  endtask
  task cmd(input logic [3:0] op, input logic [4:0] e, input logic [2:0] f, input logic [7:0] x);
    logic [7:0] c;
    logic [4:0] i;
    c = 8'hff;
    wr(`OFS_CMD, {13'h0, f, 3'h0, e, 4'h0, op});
    for (int n = 0; n < 60 && c === 8'hff; n++) begin
      @(posedge ref_clk);
      #1 if (cmpl_r.valid === 1'b1) {i, c} = {cmpl_r.idx, cmpl_r.code};
    end
    chk({i, c}, {e, x});
    if (c === 8'hff) give_verdict();
  endtask
  task pev(input logic [3:0] k, input logic [4:0] e);
    @(posedge ref_clk);
    pk <= k;
    pe <= e;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (16) @(posedge ref_clk);
  endtask
  task xf(input logic [4:0] e, input logic x);
    @(posedge ref_clk);
    req <= 1'b1;
    xe <= e;
    @(posedge ref_clk);
    req <= 1'b0;
    #1 chk(ok, x);
  endtask
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_default();
    logic [31:0] d;
    st(5'd0, EP_DISABLED);
    rd(8'h40, d);
    chk(d, 32'h0);
    cmd(`OP_ADDR_DEV, 5'd0, 3'h0, `CC_SUCCESS);
    st(5'd0, EP_RUNNING);
    cmd(`OP_STOP_EP, 5'd0, 3'h0, `CC_SUCCESS);
    cmd(`OP_CONFIG_EP, 5'd0, 3'h3, `CC_SUCCESS);
    st(5'd0, EP_STOPPED);
    wr(`OFS_DOORBELL, 32'h0);
    st(5'd0, EP_RUNNING);
    pev(`KIND_STALL, 5'd0);
    st(5'd0, EP_HALTED);
    $display("done default endpoint");
  endtask
  task t_bulk();
    logic [31:0] d;
    cmd(`OP_CONFIG_EP, 5'd2, 3'h1, `CC_SUCCESS);
    st(5'd2, EP_RUNNING);
    cmd(`OP_STOP_EP, 5'd2, 3'h0, `CC_SUCCESS);
    xf(5'd2, 1'b0);
    wr(`OFS_DOORBELL, 32'h2);
    repeat (2) @(posedge ref_clk);
    #1 chk({cw.valid, cw.idx, cw.state}, {1'b1, 5'd2, EP_RUNNING});
    st(5'd2, EP_RUNNING);
    xf(5'd2, 1'b1);
    @(posedge ref_clk);
    re <= 1'b1;
    ree <= 5'd2;
    @(posedge ref_clk);
    re <= 1'b0;
    st(5'd2, EP_RUNNING);
    rd(`OFS_ENDPOINT_STATE_FIELD, d);
    chk(d[4:0], 5'h01);
    pev(`KIND_TIMEOUT, 5'd2);
    st(5'd2, EP_HALTED);
    wr(`OFS_DOORBELL, 32'h2);
    st(5'd2, EP_HALTED);
    cmd(`OP_STOP_EP, 5'd2, 3'h0, `CC_CTX_STATE_ERR);
    cmd(`OP_RESET_EP, 5'd2, 3'h0, `CC_SUCCESS);
    st(5'd2, EP_STOPPED);
    $display("done bulk endpoint");
  endtask
  task t_error();
    cmd(`OP_CONFIG_EP, 5'd2, 3'h3, `CC_SUCCESS);
    st(5'd2, EP_RUNNING);
    pev(`KIND_TRB_ERR, 5'd2);
    st(5'd2, EP_ERROR);
    cmd(`OP_STOP_EP, 5'd2, 3'h0, `CC_CTX_STATE_ERR);
    cmd(`OP_SET_DEQ, 5'd2, 3'h0, `CC_SUCCESS);
    st(5'd2, EP_STOPPED);
    cmd(`OP_CONFIG_EP, 5'd2, 3'h2, `CC_SUCCESS);
    st(5'd2, EP_DISABLED);
    cmd(`OP_CONFIG_EP, 5'd3, 3'h1, `CC_SUCCESS);
    cmd(`OP_CONFIG_EP, 5'd0, 3'h4, `CC_SUCCESS);
    st(5'd3, EP_DISABLED);
    st(5'd0, EP_HALTED);
    cmd(`OP_DISABLE_SLOT, 5'd0, 3'h0, `CC_SUCCESS);
    st(5'd0, EP_DISABLED);
    $display("done error and disable");
  endtask
  task t_iso();
    logic [31:0] d;
    cmd(`OP_CONFIG_EP, 5'd4, 3'h1, `CC_SUCCESS);
    wr(`OFS_DOORBELL, 32'h4);
    @(posedge ref_clk);
    iso <= 1'b1;
    #1 chk(iok[4], 1'b1);
    pev(`KIND_TIMEOUT, 5'd4);
    st(5'd4, EP_RUNNING);
    rd(`OFS_ENDPOINT_STATE_FIELD, d);
    chk(d[4:0], 5'h19);
    chk(iok[4], 1'b0);
    @(posedge ref_clk);
    tick <= 1'b1;
    iso <= 1'b0;
    @(posedge ref_clk);
    tick <= 1'b0;
    @(posedge ref_clk);
    #1 chk(iok[4], 1'b1);
    cmd(`OP_RESET_DEV, 5'd0, 3'h0, `CC_SUCCESS);
    st(5'd4, EP_DISABLED);
    $display("done isoch and reset device");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_default();
    t_bulk();
    t_error();
    t_iso();
    give_verdict();
  end
endmodule
